//--- rtl/lics_defines.svh
// Offsets, field positions, reset values and timing counts of the charge sequencer
`ifndef LICS_DEFINES_SVH
`define LICS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LICS_OFS_CTRL        12'h000
`define LICS_OFS_STATUS      12'h004
`define LICS_OFS_TIMER_LO    12'h008
`define LICS_OFS_TIMER_HI    12'h00c

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define LICS_CUR_LSB         0
`define LICS_EOC_LSB         4
`define LICS_REG_BIT         8
`define LICS_CUR_DEFAULT     4'ha
`define LICS_CUR_MIN         4'h2
`define LICS_CUR_MAX         4'hf
`define LICS_CUR_USB_LOW     4'h2
`define LICS_EOC_DEFAULT     2'h0
`define LICS_EOC_LAST        2'h2
`define LICS_REG_DEFAULT     1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LICS_CLK_NS          20
`define LICS_CLK_HZ          50000000
`define LICS_SAFETY_DHR      56
`define LICS_SAFETY_CYC      (64'd`LICS_SAFETY_DHR * 64'd360 * 64'd`LICS_CLK_HZ)
`define LICS_GLITCH_NS       50
// A spike just under the window can still land on that many edges, so one more is needed
`define LICS_GLITCH_CYC      ((`LICS_GLITCH_NS + `LICS_CLK_NS - 1) / `LICS_CLK_NS + 1)

`endif

//--- rtl/lics_pkg.sv
// Types shared by the charge sequencer
package lics_pkg;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LICS_IDLE,
    LICS_PREQUAL,
    LICS_CC,
    LICS_CV,
    LICS_MAINT,
    LICS_TIMEOUT,
    LICS_TEMP_HOLD
  } lics_state_t;

  // ----------------------------------------------------------------------
  // Analog comparator and pin levels, all asynchronous to clk_sys_i
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic source_present;
    logic uv_ok;
    logic ov_ok;
    logic adaptor_ok;
    logic above_qual;
    logic at_regulation;
    logic below_eoc;
    logic below_restart;
    logic temp_ok;
    logic mode_adaptor;
    logic current_select_pin;
  } lics_sense_t;

  // ----------------------------------------------------------------------
  // Programmable charge parameters
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       reg_42v;
    logic [1:0] eoc_sel;
    logic [3:0] cur_code;
  } lics_cfg_t;

  // ----------------------------------------------------------------------
  // Drive commands toward the analog charger
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       precharge_en;
    logic       fast_en;
    logic       cv_en;
    logic       eoc;
    logic       fault;
    logic       battery_regulation_voltage;
    logic [1:0] eoc_thresh;
    logic [3:0] charge_current_level;
  } lics_drive_t;

endpackage : lics_pkg

//--- rtl/lics_charge_sequencer.sv
// Single-cell lithium-ion charge sequencer with APB control registers
//
// Operation
// - Insertion needs input checks and adaptor-good first
// - Pre-qualification drives reduced safe current, measures battery
// - Above 3.0V go to constant current
// - Adaptor default 500 mA, host reprogrammable
// - USB constant current starts at 100 mA
// - Safety timer starts entering constant current
// - Timer expiry in constant current terminates charge
// - Regulation level reached: switch to constant voltage
// - Current below threshold in CV: end-of-charge
// - Termination threshold 0.1C, 0.15C, 0.2C; default 0.1C
// - Maintenance restarts charge 200 mV below termination
// - Temperature out of range stops charging
// - Parameters take defaults until reprogrammed
// - Adaptor mode ignores current-select pin
// - USB: select high 100 mA, low 500 mA
// - USB reprogramming applies only while select low
// - Serial pins reject glitches below 50 ns
// - Temperature recovery restarts sequence, resets timer
//
// The implementer's own choices: the APB register port and the address map.
`include "lics_defines.svh"

module lics_charge_sequencer
  import lics_pkg::*;
#(
  parameter logic [39:0] SAFETY_CYCLES = 40'(`LICS_SAFETY_CYC),
  parameter int          GLITCH_CYC    = `LICS_GLITCH_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Analog side
  input  wire lics_sense_t sense_i,
  output lics_drive_t      drive_o,
  // Serial programming pins, filtered for the serial engine
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_filt_o,
  output logic             sda_filt_o
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int SW = $bits(lics_sense_t);

  logic [SW-1:0] sense_m_q;
  logic [SW-1:0] sense_s_q;
  lics_sense_t   sense;

  // The first stage is read only by the second stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sense_m_q <= '0;
      sense_s_q <= '0;
    end else begin
      sense_m_q <= sense_i;
      sense_s_q <= sense_m_q;
    end
  end

  assign sense = lics_sense_t'(sense_s_q);

  // ----------------------------------------------------------------------
  // Glitch filters on the serial pins
  // ----------------------------------------------------------------------
  localparam int GW = $clog2(GLITCH_CYC + 1);

  logic [1:0] ser_raw;
  logic [1:0] ser_filt;

  assign ser_raw    = {scl_i, sda_i};
  assign scl_filt_o = ser_filt[1];
  assign sda_filt_o = ser_filt[0];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      logic          m_q;
      logic          s_q;
      logic          out_q;
      logic [GW-1:0] cnt_q;

      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          m_q <= 1'b1;
          s_q <= 1'b1;
        end else begin
          m_q <= ser_raw[g];
          s_q <= m_q;
        end
      end

      // Output follows only after the new level held for the full window
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          out_q <= 1'b1;
          cnt_q <= '0;
        end else if (s_q == out_q) begin
          cnt_q <= '0;
        end else if (cnt_q == GW'(GLITCH_CYC - 1)) begin
          out_q <= s_q;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + GW'(1);
        end
      end

      assign ser_filt[g] = out_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    case (addr)
      `LICS_OFS_CTRL:     reg_sel = 3'h1;
      `LICS_OFS_STATUS:   reg_sel = 3'h2;
      `LICS_OFS_TIMER_LO: reg_sel = 3'h3;
      `LICS_OFS_TIMER_HI: reg_sel = 3'h4;
      default:            reg_sel = 3'h0;
    endcase
  endfunction : reg_sel

  logic setup_ph;
  logic access_ph;
  logic wr_ctrl;

  assign setup_ph  = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign wr_ctrl   = access_ph && pwrite_i && (reg_sel(paddr_i) == 3'h1);
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph && (reg_sel(paddr_i) == 3'h0);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  lics_cfg_t  cfg_q;
  logic [3:0] wr_cur;
  logic [1:0] wr_eoc;

  // Current codes below the minimum are clamped to it and eoc codes past the last fall back to the default, so the analog side never sees them
  always_comb begin
    wr_cur = pwdata_i[`LICS_CUR_LSB +: 4];
    if (wr_cur < `LICS_CUR_MIN) begin
      wr_cur = `LICS_CUR_MIN;
    end
    wr_eoc = pwdata_i[`LICS_EOC_LSB +: 2];
    if (wr_eoc > `LICS_EOC_LAST) begin
      wr_eoc = `LICS_EOC_DEFAULT;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_q.cur_code <= `LICS_CUR_DEFAULT;
      cfg_q.eoc_sel  <= `LICS_EOC_DEFAULT;
      cfg_q.reg_42v  <= `LICS_REG_DEFAULT;
    end else if (wr_ctrl) begin
      if (pstrb_i[0]) begin
        cfg_q.cur_code <= wr_cur;
        cfg_q.eoc_sel  <= wr_eoc;
      end
      if (pstrb_i[1]) begin
        cfg_q.reg_42v <= pwdata_i[`LICS_REG_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Charge current selection
  // ----------------------------------------------------------------------
  logic [3:0] cur_eff;

  // Mode pin is held by the system: low for USB, high for adaptor
  always_comb begin
    if (sense.mode_adaptor) begin
      cur_eff = cfg_q.cur_code;
    end else if (sense.current_select_pin) begin
      cur_eff = `LICS_CUR_USB_LOW;
    end else begin
      cur_eff = cfg_q.cur_code;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  lics_state_t state_q;
  lics_state_t state_d;
  logic [39:0] timer_q;
  logic        input_good;
  logic        timer_done;
  logic        timeout_flag_q;

  // Source present plus both voltage checks plus adaptor-good
  assign input_good = sense.source_present && sense.uv_ok && sense.ov_ok
                      && sense.adaptor_ok;
  assign timer_done = (timer_q >= SAFETY_CYCLES - 40'h1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      LICS_IDLE: begin
        if (input_good) begin
          state_d = LICS_PREQUAL;
        end
      end
      LICS_PREQUAL: begin
        if (sense.above_qual) begin
          state_d = LICS_CC;
        end
      end
      LICS_CC: begin
        if (timer_done) begin
          state_d = LICS_TIMEOUT;
        end else if (sense.at_regulation) begin
          state_d = LICS_CV;
        end
      end
      LICS_CV: begin
        if (sense.below_eoc) begin
          state_d = LICS_MAINT;
        end
      end
      LICS_MAINT: begin
        if (sense.below_restart) begin
          state_d = LICS_PREQUAL;
        end
      end
      LICS_TIMEOUT: begin
        state_d = LICS_TIMEOUT;
      end
      LICS_TEMP_HOLD: begin
        if (sense.temp_ok) begin
          state_d = LICS_PREQUAL;
        end
      end
      default: begin
        state_d = LICS_IDLE;
      end
    endcase
    // Temperature and input loss override every charging state
    if (state_q != LICS_IDLE && state_q != LICS_TEMP_HOLD && state_q != LICS_TIMEOUT
        && !sense.temp_ok) begin
      state_d = LICS_TEMP_HOLD;
    end
    if (state_q != LICS_IDLE && !input_good) begin
      state_d = LICS_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= LICS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Timer is zero in every state before constant current, so a restart
  // after temperature recovery always gets the full window
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer_q <= '0;
    end else if (state_q == LICS_CC || state_q == LICS_CV) begin
      if (!timer_done) begin
        timer_q <= timer_q + 40'h1;
      end
    end else begin
      timer_q <= '0;
    end
  end

  // Timeout stays visible until the source goes away
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timeout_flag_q <= 1'b0;
    end else if (state_q == LICS_CC && timer_done) begin
      timeout_flag_q <= 1'b1;
    end else if (state_q == LICS_IDLE) begin
      timeout_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drive_o <= '0;
    end else begin
      drive_o.precharge_en               <= (state_d == LICS_PREQUAL);
      drive_o.fast_en                    <= (state_d == LICS_CC);
      drive_o.cv_en                      <= (state_d == LICS_CV);
      drive_o.eoc                        <= (state_d == LICS_MAINT);
      drive_o.fault                      <= (state_d == LICS_TIMEOUT)
                                            || (state_d == LICS_TEMP_HOLD);
      drive_o.battery_regulation_voltage <= cfg_q.reg_42v;
      drive_o.eoc_thresh                 <= cfg_q.eoc_sel;
      drive_o.charge_current_level       <= cur_eff;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured in the setup phase for a zero-wait access
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_sel(paddr_i))
      3'h1: begin
        rd_mux[`LICS_CUR_LSB +: 4] = cfg_q.cur_code;
        rd_mux[`LICS_EOC_LSB +: 2] = cfg_q.eoc_sel;
        rd_mux[`LICS_REG_BIT]      = cfg_q.reg_42v;
      end
      3'h2: begin
        rd_mux[2:0]  = state_q;
        rd_mux[3]    = timeout_flag_q;
        rd_mux[4]    = sense.temp_ok;
        rd_mux[5]    = sense.mode_adaptor;
        rd_mux[6]    = sense.current_select_pin;
        rd_mux[7]    = input_good;
        rd_mux[11:8] = cur_eff;
      end
      3'h3: begin
        rd_mux = timer_q[31:0];
      end
      3'h4: begin
        rd_mux[7:0] = timer_q[39:32];
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (setup_ph && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

endmodule : lics_charge_sequencer

//--- bench/lics_charge_sequencer_sva.sv
// Port-level assertions for the charge sequencer
`include "lics_defines.svh"

module lics_charge_sequencer_sva
  import lics_pkg::*;
#(
  parameter logic [39:0] SAFETY_CYCLES = 40'd200
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire lics_sense_t sense_i,
  input wire lics_drive_t drive_o,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        scl_filt_o,
  input wire logic        sda_filt_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  logic        good;
  logic        charging;
  logic [39:0] cc_run_q;
  assign good     = sense_i.source_present & sense_i.uv_ok & sense_i.ov_ok & sense_i.adaptor_ok;
  assign charging = drive_o.precharge_en | drive_o.fast_en | drive_o.cv_en;

  // Counts the unbroken run of constant current, bounded by the safety timer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !drive_o.fast_en) begin
      cc_run_q <= '0;
    end else begin
      cc_run_q <= cc_run_q + 40'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  AST_PREQ_NEEDS_INPUT: assert property (
    $rose(drive_o.precharge_en) |-> $past(good, 3))
    else $error("precharge began without good input");
  AST_ONE_PHASE: assert property (
    $onehot0({drive_o.precharge_en, drive_o.fast_en, drive_o.cv_en, drive_o.eoc}))
    else $error("two charge phases at once");
  AST_CC_FROM_PREQ: assert property (
    $rose(drive_o.fast_en) |-> $past(drive_o.precharge_en))
    else $error("constant current not entered from precharge");
  AST_CV_FROM_CC: assert property (
    $rose(drive_o.cv_en) |-> $past(drive_o.fast_en))
    else $error("constant voltage not entered from constant current");
  AST_EOC_FROM_CV: assert property (
    $rose(drive_o.eoc) |-> $past(drive_o.cv_en))
    else $error("end of charge not reached from constant voltage");
  AST_SAFETY_BOUND: assert property (
    cc_run_q <= SAFETY_CYCLES + 40'd3)
    else $error("constant current outlived the safety timer");
  AST_TEMP_STOPS: assert property (
    (!sense_i.temp_ok) [*4] |-> !charging)
    else $error("charging with temperature out of range");
  AST_SOURCE_LOSS: assert property (
    (!sense_i.source_present) [*4] |-> !(charging | drive_o.eoc | drive_o.fault))
    else $error("sequencer not idle without source");
  AST_USB_LOW: assert property (
    (!sense_i.mode_adaptor && sense_i.current_select_pin) [*4] ##0 drive_o.fast_en
    |-> drive_o.charge_current_level == `LICS_CUR_USB_LOW)
    else $error("usb low power current wrong");
  AST_SCL_GLITCH: assert property (
    (scl_i && scl_filt_o) [*6] ##1 (!scl_i) [*2] ##1 scl_i |=> scl_filt_o [*6])
    else $error("short clock spike passed the filter");
  AST_SDA_GLITCH: assert property (
    (!sda_i && !sda_filt_o) [*6] ##1 sda_i [*2] ##1 !sda_i |=> (!sda_filt_o) [*6])
    else $error("short data spike passed the filter");
  AST_SCL_FOLLOWS: assert property (
    (!scl_i) [*8] |-> !scl_filt_o)
    else $error("steady clock level not passed");
endmodule : lics_charge_sequencer_sva

bind lics_charge_sequencer lics_charge_sequencer_sva #(
  .SAFETY_CYCLES(SAFETY_CYCLES)
) i_sva (
  .clk_sys_i (clk_sys_i),
  .rst_i     (rst_i),
  .sense_i   (sense_i),
  .drive_o   (drive_o),
  .scl_i     (scl_i),
  .sda_i     (sda_i),
  .scl_filt_o(scl_filt_o),
  .sda_filt_o(sda_filt_o)
);

//--- bench/lics_batt_model.sv
// Behavioural charging source and single-cell battery facing the sequencer
module lics_batt_model
  import lics_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        plug_i,
  input  wire logic        temp_ok_i,
  input  wire logic        mode_adaptor_i,
  input  wire logic        select_i,
  input  wire logic        stall_i,
  input  wire lics_drive_t drive_i,
  output lics_sense_t      sense_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int lvl_q  = 0;
  int tail_q = 0;

  // A removed source counts as a swapped flat cell, so every plug starts afresh
  always @(posedge clk_i) begin
    if (!plug_i) begin
      lvl_q <= 0;
    end else if ((drive_i.precharge_en || drive_i.fast_en) && !stall_i && lvl_q < 40) begin
      lvl_q <= lvl_q + 1;
    end else if (drive_i.eoc && lvl_q > 0) begin
      lvl_q <= lvl_q - 1; // Fast self-discharge keeps the restart short
    end
    tail_q <= drive_i.cv_en ? tail_q + 1 : 0;
  end

  always_comb begin
    sense_o.source_present     = plug_i;
    sense_o.uv_ok              = plug_i;
    sense_o.ov_ok              = plug_i;
    sense_o.adaptor_ok         = plug_i;
    sense_o.above_qual         = lvl_q >= 20;
    sense_o.at_regulation      = lvl_q >= 40;
    sense_o.below_eoc          = tail_q >= 10;
    sense_o.below_restart      = lvl_q <= 30;
    sense_o.temp_ok            = temp_ok_i;
    sense_o.mode_adaptor       = mode_adaptor_i;
    sense_o.current_select_pin = select_i;
  end
endmodule : lics_batt_model

//--- bench/test_lics_charge_sequencer.sv
// Self-checking bench for the charge sequencer
module test_lics_charge_sequencer
  import lics_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = '0;
  logic [31:0] pwdata_i  = '0;
  logic [3:0]  pstrb_i   = '0;
  logic        scl_i     = 1'b1;
  logic        sda_i     = 1'b1;
  logic        plug      = 1'b0;
  logic        temp_ok   = 1'b1;
  logic        mode_ad   = 1'b1;
  logic        sel       = 1'b1;
  logic        stall     = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        scl_filt_o;
  logic        sda_filt_o;
  lics_sense_t sense_i;
  lics_drive_t drive_o;
  logic [31:0] rd;
  logic        err;
  int          errors          = 0;
  int          samples_checked = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  lics_charge_sequencer #(.SAFETY_CYCLES(40'd200)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sense_i(sense_i),
    .drive_o(drive_o), .scl_i(scl_i), .sda_i(sda_i), .scl_filt_o(scl_filt_o),
    .sda_filt_o(sda_filt_o));

  lics_batt_model i_batt (
    .clk_i(clk_sys_i), .plug_i(plug), .temp_ok_i(temp_ok), .mode_adaptor_i(mode_ad),
    .select_i(sel), .stall_i(stall), .drive_i(drive_o), .sense_o(sense_i));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic stop_test;
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick

  // Drive fields are judged mid-cycle, where the edge's updates have landed
  task automatic chk_drv(input string nm, input logic [11:0] mask, input logic [11:0] exp);
    @(negedge clk_sys_i);
    chk(nm, 32'(exp), 32'(drive_o & mask));
    @(posedge clk_sys_i);
  endtask : chk_drv

  task automatic wait_ph(input int k, input string nm);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (drive_o[11-k] !== 1'b1 && n < 3000) begin
      n++;
      @(negedge clk_sys_i);
    end
    chk(nm, 32'h1, 32'(drive_o[11-k]));
    @(posedge clk_sys_i);
  endtask : wait_ph

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    pstrb_i  <= s;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk_drv("drive idle", 12'hf80, 12'h000);
    apb(1'b0, 12'h000, '0, 4'h0);
    chk("ctrl default", 32'h0000_010a, rd);
    apb(1'b1, 12'h020, 32'h0000_0003, 4'hf);
    chk("unmapped error", 32'h1, 32'(err));
  endtask : t_reset

  task automatic t_full;
    plug <= 1'b1;
    sel  <= 1'b0;
    wait_ph(0, "prequal");
    wait_ph(1, "cc");
    chk_drv("adaptor default", 12'h07f, 12'h04a);
    wait_ph(2, "cv");
    wait_ph(3, "eoc");
    wait_ph(0, "restart");
    plug <= 1'b0;
    tick(6);
    chk_drv("source removed", 12'hf80, 12'h000);
  endtask : t_full

  task automatic t_prog;
    apb(1'b1, 12'h000, 32'h0000_001f, 4'hf);
    plug <= 1'b1;
    sel  <= 1'b1;
    wait_ph(1, "prog cc");
    chk_drv("prog current", 12'h07f, 12'h01f);
    plug <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0131, 4'h1);
    apb(1'b0, 12'h000, '0, 4'h0);
    chk("clamped ctrl", 32'h0000_0002, rd);
    apb(1'b1, 12'h000, 32'h0000_010a, 4'h3);
  endtask : t_prog

  task automatic t_usb;
    mode_ad <= 1'b0;
    plug    <= 1'b1;
    wait_ph(1, "usb cc");
    stall <= 1'b1;
    chk_drv("usb start", 12'h00f, 12'h002);
    sel <= 1'b0;
    tick(6);
    chk_drv("usb select low", 12'h00f, 12'h00a);
    apb(1'b1, 12'h000, 32'h0000_012c, 4'hf);
    tick(4);
    chk_drv("usb programmed", 12'h03f, 12'h02c);
    sel <= 1'b1;
    tick(6);
    chk_drv("usb fixed low", 12'h00f, 12'h002);
    wait_ph(4, "safety timeout");
    chk_drv("timeout stops", 12'hf00, 12'h000);
    apb(1'b0, 12'h004, '0, 4'h0);
    chk("timeout state", 32'h5, 32'(rd[2:0]));
    plug    <= 1'b0;
    stall   <= 1'b0;
    mode_ad <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_010a, 4'hf);
  endtask : t_usb

  task automatic t_temp;
    plug <= 1'b1;
    wait_ph(1, "temp cc");
    temp_ok <= 1'b0;
    wait_ph(4, "temp fault");
    chk_drv("temp stops", 12'hf00, 12'h000);
    apb(1'b0, 12'h008, '0, 4'h0);
    chk("timer low cleared", 32'h0, rd);
    apb(1'b0, 12'h00c, '0, 4'h0);
    chk("timer high cleared", 32'h0, rd);
    temp_ok <= 1'b1;
    wait_ph(0, "temp restart");
    plug <= 1'b0;
    tick(6);
  endtask : t_temp

  // Spikes of two cycles are shorter than the filter's span and must vanish
  task automatic t_glitch;
    for (int i = 0; i < 2; i++) begin
      scl_i <= i[0];
      sda_i <= i[0];
      tick(2);
      scl_i <= ~i[0];
      sda_i <= ~i[0];
      repeat (8) begin
        @(negedge clk_sys_i);
        chk("spike", {30'h0, ~i[0], ~i[0]}, {30'h0, scl_filt_o, sda_filt_o});
      end
      @(posedge clk_sys_i);
      scl_i <= i[0];
      sda_i <= i[0];
      tick(14);
    end
    @(negedge clk_sys_i);
    chk("level", 32'h3, {30'h0, scl_filt_o, sda_filt_o});
  endtask : t_glitch

  initial begin
    tick(3);
    rst_i <= 1'b0;
    t_reset();
    t_full();
    t_prog();
    t_usb();
    t_temp();
    t_glitch();
    stop_test();
  end

  initial begin
    tick(20000);
    errors++;
    stop_test();
  end
endmodule : test_lics_charge_sequencer
